// >>> pmrb_top.v
`include "pmrb_map.vh"

module pmrb_top #(
  parameter [15:0] MAKER_ID = 16'h0A5C, // arbitrary value
  parameter [15:0] DIE_IDENTIFICATION   = 16'h00C3, // arbitrary value
  parameter        CLK_KHZ  = `PMRB_CLK_KHZ
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  input  wire [3:0]  addr_sel_i,
  input  wire [15:0] sense_code_i,
  input  wire [15:0] bus_code_i,
  input  wire [15:0] power_code_i,
  input  wire [15:0] current_code_i,
  output reg  [2:0]  operating_mode_o,
  output reg  [2:0]  averaging_count_select_o,
  output reg  [2:0]  bus_volt_conversion_time_o,
  output reg  [2:0]  sense_volt_conversion_time_o,
  output reg  [15:0] current_calibration_o,
  output reg  [15:0] alert_mask_enable_o,
  output reg  [15:0] alert_threshold_o,
  output wire        sense_phase_o,
  output wire        bus_phase_o,
  output wire        result_update_o
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_CMD  = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_ACK  = 3'd4;
  localparam ST_TX   = 3'd5;
  localparam ST_MACK = 3'd6;
  localparam [15:0] CFG_RST = `PMRB_CFG_RESET;

  reg [2:0]  state;
  reg [2:0]  ack_next;
  reg [3:0]  bit_cnt;
  reg [7:0]  rx_sh;
  reg [7:0]  tx_sh;
  reg        byte_sel;
  reg [7:0]  msb_hold;
  reg [7:0]  pointer;
  reg [15:0] rd_word;
  reg        mack_ok;
  reg        scl_q;
  reg        sda_q;
  reg        cfg_halt;
  reg        conv_start;
  reg [15:0] sense_result;
  reg [15:0] bus_result;
  reg [15:0] power_result;
  reg [15:0] current_result;

  wire conv_done;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire bus_start = scl_i & scl_q & sda_q & ~sda_i;
  wire bus_stop  = scl_i & scl_q & ~sda_q & sda_i;
  wire [6:0] own_addr = {`PMRB_SLAVE_BASE, addr_sel_i};
  wire [15:0] wr_word = {msb_hold, rx_sh};

  wire [15:0] cfg_word = {1'b0, 3'b100, averaging_count_select_o, bus_volt_conversion_time_o,
                          sense_volt_conversion_time_o, operating_mode_o};

  // reads are side-effect free, so a configuration read leaves the run alone
  function [15:0] reg_read;
    input [7:0] ofs;
    begin
      if (ofs == `PMRB_OFS_CONFIG) begin
        reg_read = cfg_word;
      end else if (ofs == `PMRB_OFS_SENSE) begin
        reg_read = sense_result;
      end else if (ofs == `PMRB_OFS_BUS) begin
        reg_read = bus_result;
      end else if (ofs == `PMRB_OFS_POWER) begin
        reg_read = power_result;
      end else if (ofs == `PMRB_OFS_CURRENT) begin
        reg_read = current_result;
      end else if (ofs == `PMRB_OFS_CALIB) begin
        reg_read = current_calibration_o;
      end else if (ofs == `PMRB_OFS_MASK) begin
        reg_read = alert_mask_enable_o;
      end else if (ofs == `PMRB_OFS_LIMIT) begin
        reg_read = alert_threshold_o;
      end else if (ofs == `PMRB_OFS_MAKER_ID) begin
        reg_read = MAKER_ID;
      end else if (ofs == `PMRB_OFS_DIE_IDENTIFICATION) begin
        reg_read = DIE_IDENTIFICATION;
      end else begin
        reg_read = `PMRB_ZERO_RESET;
      end
    end
  endfunction

  // the code 8000h lies outside the negative full scale and is pinned to it
  function [15:0] sense_clamp;
    input [15:0] code;
    begin
      if (code == `PMRB_SENSE_BAD_CODE) begin
        sense_clamp = `PMRB_SENSE_NEG_FS;
      end else begin
        sense_clamp = code;
      end
    end
  endfunction

  wire commit     = (state == ST_DATA) && scl_fall && (bit_cnt == 4'd8) && byte_sel;
  wire cfg_commit = commit && (pointer == `PMRB_OFS_CONFIG);
  wire soft_rst   = cfg_commit && wr_word[`PMRB_CFG_RST_BIT];

  always @(posedge clk_i) begin
    if (sys_rst_i || soft_rst) begin
      operating_mode_o             <= CFG_RST[`PMRB_CFG_MODE_HI:`PMRB_CFG_MODE_LO];
      sense_volt_conversion_time_o <= CFG_RST[`PMRB_CFG_SCT_HI:`PMRB_CFG_SCT_LO];
      bus_volt_conversion_time_o   <= CFG_RST[`PMRB_CFG_BCT_HI:`PMRB_CFG_BCT_LO];
      averaging_count_select_o     <= CFG_RST[`PMRB_CFG_AVG_HI:`PMRB_CFG_AVG_LO];
      current_calibration_o        <= `PMRB_ZERO_RESET;
      alert_mask_enable_o          <= `PMRB_ZERO_RESET;
      alert_threshold_o            <= `PMRB_ZERO_RESET;
      sense_result                 <= `PMRB_ZERO_RESET;
      bus_result                   <= `PMRB_ZERO_RESET;
      power_result                 <= `PMRB_ZERO_RESET;
      current_result               <= `PMRB_ZERO_RESET;
    end else begin
      if (commit) begin
        // result and identification offsets fall through: acked, not stored
        if (pointer == `PMRB_OFS_CONFIG) begin
          operating_mode_o             <= wr_word[`PMRB_CFG_MODE_HI:`PMRB_CFG_MODE_LO];
          sense_volt_conversion_time_o <= wr_word[`PMRB_CFG_SCT_HI:`PMRB_CFG_SCT_LO];
          bus_volt_conversion_time_o   <= wr_word[`PMRB_CFG_BCT_HI:`PMRB_CFG_BCT_LO];
          averaging_count_select_o     <= wr_word[`PMRB_CFG_AVG_HI:`PMRB_CFG_AVG_LO];
        end else if (pointer == `PMRB_OFS_CALIB) begin
          current_calibration_o <= wr_word;
        end else if (pointer == `PMRB_OFS_MASK) begin
          alert_mask_enable_o <= wr_word;
        end else if (pointer == `PMRB_OFS_LIMIT) begin
          alert_threshold_o <= wr_word;
        end
      end
      if (conv_done) begin
        if (operating_mode_o[`PMRB_MODE_SENSE_BIT]) begin
          sense_result <= sense_clamp(sense_code_i);
        end
        if (operating_mode_o[`PMRB_MODE_BUS_BIT]) begin
          bus_result <= bus_code_i;
        end
        if (operating_mode_o[`PMRB_MODE_SENSE_BIT] && operating_mode_o[`PMRB_MODE_BUS_BIT]) begin
          power_result   <= power_code_i;
          current_result <= current_code_i;
        end
      end
    end
  end

  // serial slave: pins are sampled directly, edges are found against last cycle
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state      <= ST_IDLE;
      ack_next   <= ST_IDLE;
      bit_cnt    <= 4'h0;
      rx_sh      <= 8'h00;
      tx_sh      <= 8'h00;
      byte_sel   <= 1'b0;
      msb_hold   <= 8'h00;
      pointer    <= `PMRB_OFS_CONFIG;
      rd_word    <= 16'h0000;
      mack_ok    <= 1'b0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
      cfg_halt   <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      scl_q      <= scl_i;
      sda_q      <= sda_i;
      conv_start <= 1'b0;
      if (bus_start || bus_stop) begin
        state    <= bus_start ? ST_ADDR : ST_IDLE;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
        if (cfg_halt) begin
          // an aborted write resumes conversion on the settings in place
          cfg_halt   <= 1'b0;
          conv_start <= 1'b1;
        end
      end else begin
        case (state)
          ST_ADDR, ST_CMD, ST_DATA: begin
            if (scl_rise) begin
              rx_sh   <= {rx_sh[6:0], sda_i};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'd8) begin
              bit_cnt  <= 4'h0;
              sda_o    <= 1'b0;
              sda_oe_o <= 1'b1;
              state    <= ST_ACK;
              if (state == ST_ADDR) begin
                if (rx_sh[7:1] != own_addr) begin
                  state    <= ST_IDLE;
                  sda_oe_o <= 1'b0;
                end else if (rx_sh[0]) begin
                  ack_next <= ST_TX;
                  byte_sel <= 1'b0;
                  rd_word  <= reg_read(pointer);
                end else begin
                  ack_next <= ST_CMD;
                end
              end else if (state == ST_CMD) begin
                pointer  <= rx_sh;
                ack_next <= ST_DATA;
                byte_sel <= 1'b0;
              end else begin
                ack_next <= ST_DATA;
                byte_sel <= ~byte_sel;
                msb_hold <= rx_sh;
                if (cfg_commit) begin
                  // the soft reset clears bit 15 with the rest, it is never stored
                  cfg_halt   <= 1'b0;
                  conv_start <= 1'b1;
                end else if (!byte_sel && pointer == `PMRB_OFS_CONFIG) begin
                  // halt on the first data byte: a bare pointer write before a read must not restart the run
                  cfg_halt <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state <= ack_next;
              if (ack_next == ST_TX) begin
                sda_o    <= rd_word[15];
                tx_sh    <= {rd_word[14:8], 1'b0};
                sda_oe_o <= 1'b1;
              end else begin
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'd8) begin
                sda_oe_o <= 1'b0;
                bit_cnt  <= 4'h0;
                state    <= ST_MACK;
              end else begin
                sda_o <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_ok <= ~sda_i;
            end else if (scl_fall) begin
              if (mack_ok) begin
                // after the LSB the same word is sent again, MSB first
                byte_sel <= ~byte_sel;
                state    <= ST_TX;
                sda_oe_o <= 1'b1;
                sda_o    <= byte_sel ? rd_word[15] : rd_word[7];
                tx_sh    <= byte_sel ? {rd_word[14:8], 1'b0} : {rd_word[6:0], 1'b0};
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  pmrb_conv #(
    .CLK_KHZ (CLK_KHZ)
  ) u_conv (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .mode_i        (operating_mode_o),
    .avg_i         (averaging_count_select_o),
    .sense_ct_i    (sense_volt_conversion_time_o),
    .bus_ct_i      (bus_volt_conversion_time_o),
    .halt_i        (cfg_halt),
    .start_i       (conv_start),
    .sense_phase_o (sense_phase_o),
    .bus_phase_o   (bus_phase_o),
    .done_o        (conv_done)
  );

  assign result_update_o = conv_done;

endmodule

// >>> pmrb_map.vh
`ifndef PMRB_MAP_VH
`define PMRB_MAP_VH

`define PMRB_OFS_CONFIG      8'h00
`define PMRB_OFS_SENSE       8'h01
`define PMRB_OFS_BUS         8'h02
`define PMRB_OFS_POWER       8'h03
`define PMRB_OFS_CURRENT     8'h04
`define PMRB_OFS_CALIB       8'h05
`define PMRB_OFS_MASK        8'h06
`define PMRB_OFS_LIMIT       8'h07
`define PMRB_OFS_MAKER_ID    8'hFE
`define PMRB_OFS_DIE_IDENTIFICATION      8'hFF

`define PMRB_CFG_RESET       16'h4127
`define PMRB_ZERO_RESET      16'h0000
`define PMRB_CFG_RST_BIT     15
`define PMRB_CFG_FIX_HI      14
`define PMRB_CFG_FIX_LO      12
`define PMRB_CFG_AVG_HI      11
`define PMRB_CFG_AVG_LO      9
`define PMRB_CFG_BCT_HI      8
`define PMRB_CFG_BCT_LO      6
`define PMRB_CFG_SCT_HI      5
`define PMRB_CFG_SCT_LO      3
`define PMRB_CFG_MODE_HI     2
`define PMRB_CFG_MODE_LO     0

`define PMRB_MODE_SENSE_BIT  0
`define PMRB_MODE_BUS_BIT    1
`define PMRB_MODE_CONT_BIT   2

`define PMRB_SENSE_NEG_FS    16'h8001
`define PMRB_SENSE_BAD_CODE  16'h8000

`define PMRB_SLAVE_BASE      3'h4

`define PMRB_CT_US_0         139
`define PMRB_CT_US_1         203
`define PMRB_CT_US_2         269
`define PMRB_CT_US_3         525
`define PMRB_CT_US_4         1037
`define PMRB_CT_US_5         2061
`define PMRB_CT_US_6         4109
`define PMRB_CT_US_7         8205
`define PMRB_CLK_KHZ         10000

`endif

// >>> pmrb_conv.v
`include "pmrb_map.vh"

module pmrb_conv #(
  parameter CLK_KHZ = `PMRB_CLK_KHZ,
  parameter CNT_W   = 17,
  parameter AVG_W   = 11
) (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire [2:0] mode_i,
  input  wire [2:0] avg_i,
  input  wire [2:0] sense_ct_i,
  input  wire [2:0] bus_ct_i,
  input  wire       halt_i,
  input  wire       start_i,
  output reg        sense_phase_o,
  output reg        bus_phase_o,
  output reg        done_o
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_SENSE = 2'd1;
  localparam ST_BUS   = 2'd2;

  reg [1:0]       state;
  reg [CNT_W-1:0] cyc;
  reg [AVG_W-1:0] samples;

  // rounded up: a conversion never ends early
  function [CNT_W-1:0] ct_cycles;
    input [2:0] code;
    integer us;
    integer n;
    begin
      case (code)
        3'h0: us = `PMRB_CT_US_0;
        3'h1: us = `PMRB_CT_US_1;
        3'h2: us = `PMRB_CT_US_2;
        3'h3: us = `PMRB_CT_US_3;
        3'h4: us = `PMRB_CT_US_4;
        3'h5: us = `PMRB_CT_US_5;
        3'h6: us = `PMRB_CT_US_6;
        default: us = `PMRB_CT_US_7;
      endcase
      n = (us * CLK_KHZ + 999) / 1000;
      if (n < 1) begin
        n = 1;
      end
      ct_cycles = n[CNT_W-1:0];
    end
  endfunction

  function [AVG_W-1:0] avg_count;
    input [2:0] code;
    begin
      case (code)
        3'h0: avg_count = 11'd1;
        3'h1: avg_count = 11'd4;
        3'h2: avg_count = 11'd16;
        3'h3: avg_count = 11'd64;
        3'h4: avg_count = 11'd128;
        3'h5: avg_count = 11'd256;
        3'h6: avg_count = 11'd512;
        default: avg_count = 11'd1024;
      endcase
    end
  endfunction

  wire sense_en = mode_i[`PMRB_MODE_SENSE_BIT];
  wire bus_en   = mode_i[`PMRB_MODE_BUS_BIT];
  wire cont     = mode_i[`PMRB_MODE_CONT_BIT];
  wire last_smp = (samples + 11'd1 == avg_count(avg_i));
  wire sense_end = (cyc + 17'd1 == ct_cycles(sense_ct_i));
  wire bus_end   = (cyc + 17'd1 == ct_cycles(bus_ct_i));

  // a sample set ends in the last enabled phase
  wire set_end = (state == ST_BUS && bus_end) || (state == ST_SENSE && sense_end && !bus_en);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state         <= ST_IDLE;
      cyc           <= {CNT_W{1'b0}};
      samples       <= {AVG_W{1'b0}};
      sense_phase_o <= 1'b0;
      bus_phase_o   <= 1'b0;
      done_o        <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (halt_i) begin
        // a pending configuration write freezes and discards the run
        state   <= ST_IDLE;
        cyc     <= {CNT_W{1'b0}};
        samples <= {AVG_W{1'b0}};
      end else if (start_i) begin
        cyc     <= {CNT_W{1'b0}};
        samples <= {AVG_W{1'b0}};
        if (sense_en) begin
          state <= ST_SENSE;
        end else if (bus_en) begin
          state <= ST_BUS;
        end else begin
          state <= ST_IDLE;
        end
      end else if (state != ST_IDLE) begin
        cyc <= cyc + 17'd1;
        if (state == ST_SENSE && sense_end && bus_en) begin
          state <= ST_BUS;
          cyc   <= {CNT_W{1'b0}};
        end else if (set_end) begin
          cyc <= {CNT_W{1'b0}};
          if (last_smp) begin
            done_o  <= 1'b1;
            samples <= {AVG_W{1'b0}};
            if (!cont) begin
              state <= ST_IDLE;
            end else if (sense_en) begin
              state <= ST_SENSE;
            end else begin
              state <= ST_BUS;
            end
          end else begin
            samples <= samples + 11'd1;
            state   <= sense_en ? ST_SENSE : ST_BUS;
          end
        end
      end
      sense_phase_o <= (state == ST_SENSE);
      bus_phase_o   <= (state == ST_BUS);
    end
  end

endmodule

// >>> pmrb_host.sv
module pmrb_host #(
  parameter logic [6:0] ADDR = 7'h45
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic nack_seen = 1'b0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // each change lands 10 ns after an edge and holds four cycles
  task automatic step(input logic scl, input logic low);
    @(posedge clk_i);
    #10;
    scl_o = scl;
    sda_low_o = low;
    repeat (3) @(posedge clk_i);
  endtask
  // data moves only while the clock is low, so no false start or stop
  task automatic xbit(input logic b, output logic r);
    step(1'b0, sda_low_o);
    step(1'b0, ~b);
    step(1'b1, ~b);
    r = sda_i;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic nb, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(nb, a);
  endtask
  task automatic start_cond();
    step(1'b1, 1'b1);
  endtask
  task automatic stop_cond();
    step(1'b0, sda_low_o);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic full);
    logic [7:0] q;
    logic [3:0] a;
    a = 4'h0;
    start_cond();
    xbyte({ADDR, 1'b0}, 1'b1, q, a[0]);
    xbyte(p, 1'b1, q, a[1]);
    if (full) begin
      xbyte(d[15:8], 1'b1, q, a[2]);
      xbyte(d[7:0], 1'b1, q, a[3]);
    end
    stop_cond();
    if (a != 4'h0) nack_seen = 1'b1;
  endtask
  // master acks the first byte and refuses the second to end the read
  task automatic rd(output logic [15:0] d);
    logic a;
    start_cond();
    xbyte({ADDR, 1'b1}, 1'b1, d[15:8], a);
    if (a) nack_seen = 1'b1;
    xbyte(8'hFF, 1'b0, d[15:8], a);
    xbyte(8'hFF, 1'b1, d[7:0], a);
    stop_cond();
  endtask
endmodule

// >>> pmrb_assertions.sv
module pmrb_chk (
  input logic        clk_i,
  input logic        sys_rst_i,
  input logic        scl_i,
  input logic        sda_o,
  input logic        sda_oe_o,
  input logic [2:0]  operating_mode_o,
  input logic [2:0]  averaging_count_select_o,
  input logic [2:0]  bus_volt_conversion_time_o,
  input logic [2:0]  sense_volt_conversion_time_o,
  input logic [15:0] current_calibration_o,
  input logic [15:0] alert_mask_enable_o,
  input logic [15:0] alert_threshold_o,
  input logic        sense_phase_o,
  input logic        bus_phase_o,
  input logic        result_update_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_cfg_default;
    operating_mode_o == 3'h7 && averaging_count_select_o == 3'h0 &&
    bus_volt_conversion_time_o == 3'h4 && sense_volt_conversion_time_o == 3'h4;
  endsequence
  sequence s_mode_off;
    operating_mode_o[1:0] == 2'b00 [*2];
  endsequence
  a_reset_config: assert property (disable iff (1'b0) sys_rst_i |=> s_cfg_default)
    else $error("config fields not at reset value");
  a_reset_zero: assert property (disable iff (1'b0) sys_rst_i |=> current_calibration_o == 16'h0000 &&
    alert_mask_enable_o == 16'h0000 && alert_threshold_o == 16'h0000 && !result_update_o)
    else $error("writable registers not cleared by reset");
  a_update_pulse: assert property (result_update_o |=> !result_update_o)
    else $error("result update longer than one cycle");
  a_sense_mode: assert property (sense_phase_o |-> operating_mode_o[0])
    else $error("sense phase without sense mode");
  a_bus_mode: assert property (bus_phase_o |-> operating_mode_o[1])
    else $error("bus phase without bus mode");
  a_mode_idle: assert property (s_mode_off |-> !sense_phase_o && !bus_phase_o && !result_update_o)
    else $error("conversion running with measuring off");
  a_sda_stands: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o) && $stable(sda_o))
    else $error("data line changed while serial clock high");
  a_cfg_on_low: assert property ($changed(averaging_count_select_o) |-> !scl_i)
    else $error("config changed outside a clock low phase");
  a_cal_on_low: assert property ($changed(current_calibration_o) |-> !scl_i)
    else $error("calibration changed outside a clock low phase");
endmodule

// >>> pmrb_top_test.sv
module pmrb_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0]  ptr;
    logic        wr;
    logic [15:0] wdat;
    logic [15:0] exp;
  } pmrb_row_t;
  localparam logic [15:0] MAKER = 16'h3C69; // arbitrary value
  localparam logic [15:0] DIE   = 16'h0B17; // arbitrary value
  localparam pmrb_row_t ROWS [12] = '{
    '{8'h00, 1'b0, 16'h0000, 16'h4127}, '{8'h05, 1'b1, 16'hA5C3, 16'hA5C3},
    '{8'h06, 1'b1, 16'h5A3C, 16'h5A3C}, '{8'h07, 1'b1, 16'hFFFF, 16'hFFFF},
    '{8'h01, 1'b1, 16'h1234, 16'h0000}, '{8'h02, 1'b0, 16'h0000, 16'h0000},
    '{8'h03, 1'b0, 16'h0000, 16'h0000}, '{8'h04, 1'b1, 16'h4321, 16'h0000},
    '{8'hFE, 1'b1, 16'h1111, MAKER},    '{8'hFF, 1'b0, 16'h0000, DIE},
    '{8'h20, 1'b1, 16'h1111, 16'h0000}, '{8'h00, 1'b1, 16'h0DB0, 16'h4DB0}
  };
  localparam int CT_US [8] = '{139, 203, 269, 525, 1037, 2061, 4109, 8205};
  localparam int AVG_N [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        scl_i, sda_o, sda_oe_o, host_low, sense_phase_o, bus_phase_o, result_update_o;
  logic [15:0] sense_code_i = 16'h8000;
  logic [15:0] bus_code_i = 16'h2468;
  logic [15:0] power_code_i = 16'h1357;
  logic [15:0] current_code_i = 16'hFEDC;
  logic [2:0]  operating_mode_o, averaging_count_select_o, bus_volt_conversion_time_o, sense_volt_conversion_time_o;
  logic [15:0] current_calibration_o, alert_mask_enable_o, alert_threshold_o;
  // the block only pulls low, when enabled with sda_o low; a released line floats high
  wire         sda_i = !host_low && !(sda_oe_o && !sda_o);
  int          err_total = 0;
  int          checks_done = 0;
  int          sp_cnt, bp_cnt, up_cnt, gap_cnt;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (!sense_phase_o && !bus_phase_o) gap_cnt++;
    if (sense_phase_o) sp_cnt++;
    if (bus_phase_o) bp_cnt++;
    if (result_update_o) up_cnt++;
  end
  pmrb_top #(.MAKER_ID(MAKER), .DIE_IDENTIFICATION(DIE), .CLK_KHZ(10)) u_pmrb_top (
    .clk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_sel_i(4'h5),
    .sense_code_i, .bus_code_i, .power_code_i, .current_code_i, .operating_mode_o,
    .averaging_count_select_o, .bus_volt_conversion_time_o, .sense_volt_conversion_time_o,
    .current_calibration_o, .alert_mask_enable_o, .alert_threshold_o,
    .sense_phase_o, .bus_phase_o, .result_update_o);
  pmrb_host u_pmrb_host (.clk_i, .sda_i, .scl_o(scl_i), .sda_low_o(host_low));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd_at(input logic [7:0] p, output logic [15:0] v);
    u_pmrb_host.wr(p, 16'h0000, 1'b0);
    u_pmrb_host.rd(v);
  endtask
  // counters are cleared off the edge; the wait is bounded by the longest averaged run
  task automatic run_conv(input logic [15:0] cfg);
    @(posedge clk_i);
    #10;
    sp_cnt = 0;
    bp_cnt = 0;
    up_cnt = 0;
    u_pmrb_host.wr(8'h00, cfg, 1'b1);
    for (int n = 0; n < 3000 && up_cnt == 0; n++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    #10;
  endtask
  task give_verdict;
    $display("checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
  initial begin
    logic [15:0] v;
    repeat (2) @(posedge clk_i);
    #10;
    sys_rst_i = 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) u_pmrb_host.wr(ROWS[i].ptr, ROWS[i].wdat, 1'b1);
      rd_at(ROWS[i].ptr, v);
      chk("register", ROWS[i].exp, v);
    end
    chk("fields", 16'h0DB0, {4'h0, averaging_count_select_o, bus_volt_conversion_time_o,
      sense_volt_conversion_time_o, operating_mode_o});
    u_pmrb_host.rd(v);
    chk("kept pointer", 16'h4DB0, v);
    run_conv(16'h0003);
    chk("updates", 16'h0001, 16'(up_cnt));
    for (int r = 1; r < 5; r++) begin
      rd_at(8'(r), v);
      chk("result", r == 1 ? 16'h8001 : r == 2 ? bus_code_i : r == 3 ? power_code_i : current_code_i, v);
    end
    for (int m = 0; m < 4; m++) begin
      run_conv(16'(m));
      chk("sense ran", 16'(m & 1), 16'(sp_cnt > 0));
      chk("bus ran", 16'(m >> 1), 16'(bp_cnt > 0));
    end
    for (int c = 0; c < 8; c++) begin
      run_conv(16'((c << 6) | (c << 3) | 3));
      chk("sense time", 16'((CT_US[c] * 10 + 999) / 1000), 16'(sp_cnt));
      chk("bus time", 16'((CT_US[c] * 10 + 999) / 1000), 16'(bp_cnt));
    end
    for (int a = 0; a < 8; a++) begin
      run_conv(16'((a << 9) | 1));
      chk("averaged", 16'(AVG_N[a] * 2), 16'(sp_cnt));
    end
    run_conv(16'h0007);
    up_cnt = 0;
    gap_cnt = 0;
    rd_at(8'h00, v);
    chk("config read", 16'h4007, v);
    chk("runs on", 16'h0001, 16'(up_cnt > 20));
    chk("conversion gap", 16'h0000, 16'(gap_cnt));
    u_pmrb_host.wr(8'h06, 16'hBEEF, 1'b1);
    u_pmrb_host.wr(8'h00, 16'h8000, 1'b1);
    rd_at(8'h00, v);
    chk("soft reset config", 16'h4127, v);
    rd_at(8'h06, v);
    chk("soft reset mask", 16'h0000, v);
    u_pmrb_host.wr(8'h05, 16'h1111, 1'b1);
    @(posedge clk_i);
    #10;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #10;
    sys_rst_i = 1'b0;
    rd_at(8'h05, v);
    chk("reset calibration", 16'h0000, v);
    rd_at(8'h01, v);
    chk("reset result", 16'h0000, v);
    chk("host acks", 16'h0000, 16'(u_pmrb_host.nack_seen));
    give_verdict();
  end
endmodule
bind pmrb_top pmrb_chk u_chk (.clk_i, .sys_rst_i, .scl_i, .sda_o, .sda_oe_o, .operating_mode_o,
  .averaging_count_select_o, .bus_volt_conversion_time_o, .sense_volt_conversion_time_o,
  .current_calibration_o, .alert_mask_enable_o, .alert_threshold_o, .sense_phase_o, .bus_phase_o,
  .result_update_o);
